// [include/tpi_pkg.sv]
package tpi_pkg;

  // Image geometry
  localparam int IMG_BYTES  = 12;
  localparam int DATA_BYTES = 11;
  localparam int DATA_W     = 88;
  localparam int BYTE_W     = 8;

  // Command and status byte fields
  localparam int CMD_MODE_BIT = 7;
  localparam int CMD_DIR_BIT  = 6;
  localparam int CMD_NEXT_BIT = 0;
  localparam int IDX_W        = 6;
  localparam int STS_MODE_BIT = 7;
  localparam int STS_ERR_BIT  = 6;
  localparam int STS_FULL_BIT = 3;
  localparam int STS_NEW_BIT  = 2;
  localparam int STS_SAME_BIT = 1;
  localparam int STS_ACK_BIT  = 0;

  // Register bank
  localparam int             REG_W       = 16;
  localparam int             REG_NUM     = 64;
  localparam logic [5:0]     CMD_REG_IDX = 6'h07;
  localparam logic [15:0]    REG_RST     = 16'h0000;

  // Telegram buffer
  localparam int FIFO_DEPTH = 32;
  localparam int TEL_W      = 90;

  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [87:0] DATA_RST   = 88'h0;

  typedef enum logic {TPI_MODE_PD, TPI_MODE_REG} tpi_mode_t;

  // Status byte for register communication: acknowledge, direction, index
  function automatic logic [7:0] reg_status(input logic dir, input logic [5:0] idx);
    reg_status = {1'b1, dir, idx};
  endfunction

endpackage

// [rtl/tpi_fifo.sv]
`timescale 1ns/1ps
module tpi_fifo #(
  parameter int WIDTH = 90,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  // Fill side
  input  wire logic                       in_valid_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  output logic                            in_ready_o,
  // Drain side
  output logic                            out_valid_o,
  output logic [WIDTH-1:0]                out_data_o,
  input  wire logic                       out_ready_i,
  // Level
  output logic [$clog2(DEPTH):0]          count_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem[rd_ptr_ff];
  assign count_o     = count_ff;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count  = count_ff;
    if (push && !pop)
    begin
      nxt_count = count_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  // Storage needs no reset; only occupied slots are ever read
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

endmodule

// [rtl/tpi_regbank.sv]
`timescale 1ns/1ps
module tpi_regbank (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Write port
  input  wire logic        wr_en_i,
  input  wire logic [5:0]  wr_idx_i,
  input  wire logic [15:0] wr_data_i,
  // Read port
  input  wire logic [5:0]  rd_idx_i,
  output logic      [15:0] rd_data_o,
  // Command register contents
  output logic      [15:0] cmd_reg_o
);
  logic [15:0] mem_ff  [tpi_pkg::REG_NUM];
  logic [15:0] nxt_mem [tpi_pkg::REG_NUM];

  assign rd_data_o = mem_ff[rd_idx_i];
  assign cmd_reg_o = mem_ff[tpi_pkg::CMD_REG_IDX];

  always_comb
  begin
    for (int i = 0; i < tpi_pkg::REG_NUM; i++)
    begin
      nxt_mem[i] = mem_ff[i];
    end
    if (wr_en_i)
    begin
      nxt_mem[wr_idx_i] = wr_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < tpi_pkg::REG_NUM; i++)
    begin
      if (!rst_n_i)
      begin
        mem_ff[i] <= tpi_pkg::REG_RST;
      end
      else
      begin
        mem_ff[i] <= nxt_mem[i];
      end
    end
  end

endmodule

// [rtl/tpi_terminal_image.sv]
`timescale 1ns/1ps
module tpi_terminal_image (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  // Output image from the controller
  input  wire logic        XCHG_I,
  input  wire logic [7:0]  HOST_COMMAND_BYTE_I,
  input  wire logic [87:0] OUTBOUND_DATA_BYTE_I,
  // Input image toward the controller
  output logic      [7:0]  TERMINAL_STATUS_BYTE_O,
  output logic      [87:0] INBOUND_DATA_BYTE_O,
  output logic             REGISTER_COMM_SELECT_O,
  // Received telegram stream
  input  wire logic        RX_VALID_I,
  input  wire logic [87:0] RX_DATA_I,
  input  wire logic        RX_ERR_I,
  input  wire logic        RX_SAME_I,
  output logic             RX_READY_O,
  // Command register contents
  output logic      [15:0] CMD_REG_O
);

  localparam int CW = $clog2(tpi_pkg::FIFO_DEPTH) + 1;

  // Decoded command byte
  logic              cmd_mode;
  logic              cmd_dir;
  logic [5:0]        cmd_idx;
  logic              cmd_next;
  logic              reg_wr;
  logic [15:0]       reg_rd_data;
  logic [15:0]       reg_wr_data;

  // Telegram buffer
  logic              fifo_valid;
  logic [89:0]       fifo_data;
  logic              fifo_pop;
  logic [CW-1:0]     fifo_count;
  logic              fifo_full;

  // Image state
  tpi_pkg::tpi_mode_t mode_ff;
  tpi_pkg::tpi_mode_t nxt_mode;
  logic [7:0]         status_ff;
  logic [7:0]         nxt_status;
  logic [87:0]        data_ff;
  logic [87:0]        nxt_data;
  logic [87:0]        tel_ff;
  logic [87:0]        nxt_tel;
  logic               tel_err_ff;
  logic               nxt_tel_err;
  logic               tel_same_ff;
  logic               nxt_tel_same;
  logic               ack_ff;
  logic               nxt_ack;
  logic               new_tel;

  assign cmd_mode    = HOST_COMMAND_BYTE_I[tpi_pkg::CMD_MODE_BIT];
  assign cmd_dir     = HOST_COMMAND_BYTE_I[tpi_pkg::CMD_DIR_BIT];
  assign cmd_idx     = HOST_COMMAND_BYTE_I[tpi_pkg::IDX_W-1:0];
  assign cmd_next    = HOST_COMMAND_BYTE_I[tpi_pkg::CMD_NEXT_BIT];
  // Data byte 0 is the low half of the word, data byte 1 the high half
  assign reg_wr_data = OUTBOUND_DATA_BYTE_I[15:0];
  assign reg_wr      = XCHG_I && cmd_mode && cmd_dir;

  // A new telegram is only copied when the request bit has been toggled
  assign fifo_pop    = XCHG_I && !cmd_mode && (cmd_next != ack_ff) && fifo_valid;
  assign fifo_full   = (fifo_count == CW'(tpi_pkg::FIFO_DEPTH));
  assign new_tel     = fifo_pop ? (fifo_count > CW'(1)) : fifo_valid;

  tpi_regbank u_regs (
    .clk_i     (REF_CLK_I),
    .rst_n_i   (RST_N_I),
    .wr_en_i   (reg_wr),
    .wr_idx_i  (cmd_idx),
    .wr_data_i (reg_wr_data),
    .rd_idx_i  (cmd_idx),
    .rd_data_o (reg_rd_data),
    .cmd_reg_o (CMD_REG_O)
  );

  // Stalls the telegram source once all 32 slots hold unfetched telegrams
  tpi_fifo #(
    .WIDTH (tpi_pkg::TEL_W),
    .DEPTH (tpi_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (RST_N_I),
    .in_valid_i  (RX_VALID_I),
    .in_data_i   ({RX_SAME_I, RX_ERR_I, RX_DATA_I}),
    .in_ready_o  (RX_READY_O),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop),
    .count_o     (fifo_count)
  );

  always_comb
  begin
    nxt_mode     = mode_ff;
    nxt_status   = status_ff;
    nxt_data     = data_ff;
    nxt_tel      = tel_ff;
    nxt_tel_err  = tel_err_ff;
    nxt_tel_same = tel_same_ff;
    nxt_ack      = ack_ff;
    if (fifo_pop)
    begin
      nxt_tel      = fifo_data[87:0];
      nxt_tel_err  = fifo_data[88];
      nxt_tel_same = fifo_data[89];
      nxt_ack      = cmd_next;
    end
    // The image is refreshed once per exchange and held in between
    if (XCHG_I)
    begin
      nxt_mode = cmd_mode ? tpi_pkg::TPI_MODE_REG : tpi_pkg::TPI_MODE_PD;
      unique case (nxt_mode)
        tpi_pkg::TPI_MODE_REG:
        begin
          // Echo of the request acknowledges it; telegram data stays hidden
          nxt_status = tpi_pkg::reg_status(cmd_dir, cmd_idx);
          nxt_data   = tpi_pkg::DATA_RST;
          if (!cmd_dir)
          begin
            nxt_data[15:0] = reg_rd_data;
          end
        end
        tpi_pkg::TPI_MODE_PD:
        begin
          nxt_status                        = tpi_pkg::STATUS_RST;
          nxt_status[tpi_pkg::STS_MODE_BIT] = 1'b0;
          nxt_status[tpi_pkg::STS_ERR_BIT]  = nxt_tel_err;
          nxt_status[tpi_pkg::STS_FULL_BIT] = fifo_full;
          nxt_status[tpi_pkg::STS_NEW_BIT]  = new_tel;
          nxt_status[tpi_pkg::STS_SAME_BIT] = nxt_tel_same;
          nxt_status[tpi_pkg::STS_ACK_BIT]  = nxt_ack;
          nxt_data                          = nxt_tel;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (!RST_N_I)
    begin
      mode_ff     <= tpi_pkg::TPI_MODE_PD;
      status_ff   <= tpi_pkg::STATUS_RST;
      data_ff     <= tpi_pkg::DATA_RST;
      tel_ff      <= tpi_pkg::DATA_RST;
      tel_err_ff  <= 1'b0;
      tel_same_ff <= 1'b0;
      ack_ff      <= 1'b0;
    end
    else
    begin
      mode_ff     <= nxt_mode;
      status_ff   <= nxt_status;
      data_ff     <= nxt_data;
      tel_ff      <= nxt_tel;
      tel_err_ff  <= nxt_tel_err;
      tel_same_ff <= nxt_tel_same;
      ack_ff      <= nxt_ack;
    end
  end

  // Byte 0 of the input image is the status byte, bytes 1 to 11 the data
  assign TERMINAL_STATUS_BYTE_O = status_ff;
  assign INBOUND_DATA_BYTE_O    = data_ff;
  assign REGISTER_COMM_SELECT_O = (mode_ff == tpi_pkg::TPI_MODE_REG);

  default clocking clk_main @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_reg_ack_index: assert property (
    XCHG_I && cmd_mode |=> TERMINAL_STATUS_BYTE_O[7] &&
      (TERMINAL_STATUS_BYTE_O[5:0] == $past(cmd_idx)))
    else $error("register access not acknowledged with its index");

  a_dir_echo: assert property (
    XCHG_I && cmd_mode |=> TERMINAL_STATUS_BYTE_O[6] == $past(cmd_dir))
    else $error("direction bit not echoed in status byte");

  a_pd_mode_bit: assert property (
    XCHG_I && !cmd_mode |=> !TERMINAL_STATUS_BYTE_O[7] && !REGISTER_COMM_SELECT_O)
    else $error("process-data mode shows register access");

  a_reg_data_zero: assert property (
    XCHG_I && cmd_mode |=> INBOUND_DATA_BYTE_O[87:16] == 72'h0)
    else $error("process data not zero during register communication");

  a_read_low_first: assert property (
    XCHG_I && cmd_mode && !cmd_dir |=>
      (INBOUND_DATA_BYTE_O[7:0] == $past(reg_rd_data[7:0])) &&
      (INBOUND_DATA_BYTE_O[15:8] == $past(reg_rd_data[15:8])))
    else $error("register read word not placed low byte first");

  a_write_stores: assert property (
    reg_wr && (cmd_idx == tpi_pkg::CMD_REG_IDX) |=>
      CMD_REG_O == $past(OUTBOUND_DATA_BYTE_I[15:0]))
    else $error("register write did not store the outbound word");

  a_image_held: assert property (
    !XCHG_I |=> $stable(TERMINAL_STATUS_BYTE_O) && $stable(INBOUND_DATA_BYTE_O))
    else $error("input image changed without an exchange");

  a_telegram_load: assert property (
    fifo_pop |=> (INBOUND_DATA_BYTE_O == $past(fifo_data[87:0])) &&
      (TERMINAL_STATUS_BYTE_O[0] == $past(cmd_next)))
    else $error("telegram copy or acknowledge wrong");

  a_mode_select: assert property (
    XCHG_I ##1 !XCHG_I [*2] |-> REGISTER_COMM_SELECT_O == $past(cmd_mode, 2))
    else $error("mode indication does not follow command byte");

  // Mode output and status mode bit are loaded by the same exchange
  a_select_status: assert property (
    REGISTER_COMM_SELECT_O == TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_MODE_BIT])
    else $error("mode output disagrees with status mode bit");

  a_select_held: assert property (
    !XCHG_I |=> $stable(REGISTER_COMM_SELECT_O))
    else $error("mode output changed without an exchange");

  a_write_data_zero: assert property (
    XCHG_I && cmd_mode && cmd_dir |=> INBOUND_DATA_BYTE_O == 88'h0)
    else $error("register write shows non-zero inbound data");

  // A stray write would silently change the terminal's settings
  a_cmd_reg_hold: assert property (
    !(reg_wr && (cmd_idx == tpi_pkg::CMD_REG_IDX)) |=>
      $stable(CMD_REG_O))
    else $error("command register changed without a write");

  // Process-data flags are judged against the buffer itself
  a_ready_not_full: assert property (
    RX_READY_O == !fifo_full)
    else $error("telegram ready does not mirror buffer level");

  a_full_flag: assert property (
    XCHG_I && !cmd_mode |=>
      TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_FULL_BIT] == $past(fifo_full))
    else $error("buffer full flag wrong in status byte");

  a_new_flag_hold: assert property (
    XCHG_I && !cmd_mode && !fifo_pop |=>
      TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_NEW_BIT] == $past(fifo_valid))
    else $error("new telegram flag wrong without a copy");

  a_new_flag_pop: assert property (
    fifo_pop |=>
      TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_NEW_BIT] == ($past(fifo_count) > CW'(1)))
    else $error("new telegram flag wrong after a copy");

  a_err_same_load: assert property (
    fifo_pop |=>
      (TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_ERR_BIT] == $past(fifo_data[88])) &&
      (TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_SAME_BIT] == $past(fifo_data[89])))
    else $error("error or same flag not taken from the telegram");

  a_reserved_clear: assert property (
    XCHG_I && !cmd_mode |=>
      TERMINAL_STATUS_BYTE_O[5:4] == 2'h0)
    else $error("reserved status bits set in process-data mode");

  a_ack_kept: assert property (
    XCHG_I && !cmd_mode && !fifo_pop |=>
      TERMINAL_STATUS_BYTE_O[tpi_pkg::STS_ACK_BIT] == $past(ack_ff))
    else $error("acknowledge moved without a telegram copy");

  a_tel_reappear: assert property (
    XCHG_I && !cmd_mode && !fifo_pop |=>
      INBOUND_DATA_BYTE_O == $past(tel_ff))
    else $error("held telegram not shown in process-data mode");

  // Register traffic must leave queued telegrams where they are
  a_reg_keeps_fifo: assert property (
    XCHG_I && cmd_mode && !RX_VALID_I |=>
      fifo_count == $past(fifo_count))
    else $error("register exchange consumed a telegram");

  c_reg_read: cover property (XCHG_I && cmd_mode && !cmd_dir ##2 XCHG_I && !cmd_mode);
  c_reg_write: cover property (reg_wr ##[1:20] XCHG_I && cmd_mode && !cmd_dir);
  c_telegram: cover property (fifo_pop);
  c_fifo_full: cover property (fifo_full && RX_VALID_I);
  // Refill right after a drain while full exercises the stall path
  c_refill_full: cover property (fifo_full && fifo_pop ##[1:4] fifo_full && fifo_pop);

endmodule

// [tb/tpi_coupler_model.sv]
`timescale 1ns/1ps
module tpi_coupler_model (
  // Clock
  input  wire logic        clk_i,
  // Image toward the terminal
  output logic             xchg_o,
  output logic [7:0]       cmd_o,
  output logic [87:0]      data_o,
  // Image from the terminal
  input  wire logic [7:0]  status_i
);
  initial
  begin
    xchg_o = 1'b0;
    cmd_o  = 8'h5A;
    data_o = '1;
  end

  // A register request is repeated until echoed, up to four exchanges; one exchange is the norm
  task automatic xchg(input logic [7:0] c, input logic [87:0] d);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      xchg_o <= 1'b1;
      cmd_o  <= c;
      data_o <= d;
      @(posedge clk_i);
      xchg_o <= 1'b0;
      // Released lines show the inverse so a stale value cannot pass
      cmd_o  <= ~c;
      data_o <= ~d;
      @(negedge clk_i);
      n++;
    end
    while (c[7] && status_i !== c && n < 4);
  endtask
endmodule

// [tb/tpi_terminal_image_bench.sv]
`timescale 1ns/1ps
module tpi_terminal_image_bench;
  logic        clk;
  logic        rst_n;
  logic        xchg;
  logic        rx_valid;
  logic        rx_err;
  logic        rx_same;
  logic        rx_ready;
  logic        sel;
  logic [7:0]  cmd;
  logic [7:0]  status;
  logic [87:0] odata;
  logic [87:0] idata;
  logic [87:0] rx_data;
  logic [15:0] cmd_reg;
  int          error_cnt;
  int          check_count;

  tpi_terminal_image u_tpi_terminal_image (
    .REF_CLK_I              (clk),
    .RST_N_I                (rst_n),
    .XCHG_I                 (xchg),
    .HOST_COMMAND_BYTE_I    (cmd),
    .OUTBOUND_DATA_BYTE_I   (odata),
    .TERMINAL_STATUS_BYTE_O (status),
    .INBOUND_DATA_BYTE_O    (idata),
    .REGISTER_COMM_SELECT_O (sel),
    .RX_VALID_I             (rx_valid),
    .RX_DATA_I              (rx_data),
    .RX_ERR_I               (rx_err),
    .RX_SAME_I              (rx_same),
    .RX_READY_O             (rx_ready),
    .CMD_REG_O              (cmd_reg)
  );

  tpi_coupler_model u_tpi_coupler_model (
    .clk_i    (clk),
    .xchg_o   (xchg),
    .cmd_o    (cmd),
    .data_o   (odata),
    .status_i (status)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [87:0] seen, input logic [87:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Chunk is held until a ready edge takes it
  task automatic push(input logic [87:0] d, input logic err, input logic same);
    int n;
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= d;
    rx_err   <= err;
    rx_same  <= same;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rx_ready !== 1'b1 && n < 50);
    if (rx_ready !== 1'b1)
      error_cnt++;
  endtask

  task automatic rx_release();
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask

  task automatic t_reset();
    chk("status", 88'(status), 88'h0);
    chk("inbound", idata, 88'h0);
    chk("select", 88'(sel), 88'h0);
    chk("ready", 88'(rx_ready), 88'h1);
    chk("cmd_reg", 88'(cmd_reg), 88'h0);
    $display("reset test done");
  endtask

  task automatic t_register();
    u_tpi_coupler_model.xchg(8'hC7, 88'hFFEEDDCCBBAA998877A55A);
    chk("status", 88'(status), 88'hC7);
    chk("inbound", idata, 88'h0);
    chk("select", 88'(sel), 88'h1);
    chk("cmd_reg", 88'(cmd_reg), 88'hA55A);
    u_tpi_coupler_model.xchg(8'hFF, 88'h1234);
    u_tpi_coupler_model.xchg(8'hBF, 88'hFFFF);
    chk("status", 88'(status), 88'hBF);
    chk("inbound", idata, 88'h1234);
    u_tpi_coupler_model.xchg(8'h80, 88'h0);
    chk("status", 88'(status), 88'h80);
    chk("inbound", idata, 88'h0);
    $display("register test done");
  endtask

  task automatic t_pd();
    push(88'h0A0B0C0D0E0F1011121314, 1'b1, 1'b1);
    rx_release();
    u_tpi_coupler_model.xchg(8'h01, 88'h0);
    chk("inbound", idata, 88'h0A0B0C0D0E0F1011121314);
    chk("status", 88'(status), 88'h43);
    chk("select", 88'(sel), 88'h0);
    u_tpi_coupler_model.xchg(8'h86, 88'h0);
    chk("inbound", idata, 88'h0);
    u_tpi_coupler_model.xchg(8'h01, 88'h0);
    chk("inbound", idata, 88'h0A0B0C0D0E0F1011121314);
    chk("status", 88'(status), 88'h43);
    $display("process data test done");
  endtask

  task automatic t_fill();
    logic [7:0] c;
    for (int k = 0; k < 32; k++)
      push({11{8'(k + 16)}}, 1'b0, 1'b0);
    // A 33rd chunk is held against the full buffer until a copy frees a slot
    @(posedge clk);
    rx_data <= {11{8'h30}};
    @(negedge clk);
    chk("ready", 88'(rx_ready), 88'h0);
    // Buffer drains while the source stalls; the held chunk refills it once
    for (int k = 0; k < 33; k++)
    begin
      c = (k % 2 == 0) ? 8'h00 : 8'h01;
      u_tpi_coupler_model.xchg(c, 88'h0);
      chk("inbound", idata, {11{8'(k + 16)}});
      chk("status", 88'(status), 88'({k < 2, k < 32, 1'b0, c[0]}));
      if (k == 0)
      begin
        chk("ready", 88'(rx_ready), 88'h1);
        rx_release();
      end
    end
    // A toggle against an empty buffer copies nothing and keeps the acknowledge
    u_tpi_coupler_model.xchg(8'h01, 88'h0);
    chk("status", 88'(status), 88'h00);
    chk("inbound", idata, {11{8'h30}});
    $display("fill test done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    error_cnt   = 0;
    check_count = 0;
    rst_n       = 1'b0;
    rx_valid    = 1'b0;
    rx_err      = 1'b0;
    rx_same     = 1'b0;
    rx_data     = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_register();
    t_pd();
    t_fill();
    stop_test();
  end

  // Whole run needs about 120 cycles
  initial
  begin
    #(5000 * 40);
    error_cnt++;
    stop_test();
  end
endmodule
